// ==== src/bpc_pkg.sv ====
// Constants for the first buck converter power-state configuration block.
// Assumes an APB master on the same clock as the block.
// How it works
// R01 - Hardware voltage choice bit 10: 0 uses active code, 1 uses sleep code
// R02 - Hardware mode field 9:8: FCCM, off, LDO, hysteretic; resets to 11
// R03 - Threshold field 6:4 gives 125mA per step from 125mA to 1000mA
// R04 - High current detection runs only while enable bit 0 is set
// R05 - Startup slot 15:13: 000 off, 1..5 timeslots, 110/111 hardware enables
// R06 - Active mode 9:8: FCCM, auto pulse-skip, LDO, hysteretic
// R07 - Active 7-bit voltage code in 12.5mV steps, 0.6V to 1.8V clamped
// R08 - Upper five active code bits may load from start-up memory, 50mV steps
// R09 - Software keeps codes at or below 48h when switching at 4MHz
// R10 - Sleep slot 15:13: 000 transition slot5, 1..5 disable slot 5..1, 110/111
// R11 - Under hardware enable, sleep codes 001-101 pick sleep-entry timeslot
// R12 - Sleep mode 9:8 selects the converter mode used in sleep state
// R13 - Sleep 7-bit code 6:0 uses the same voltage coding and 4MHz ceiling
// R14 - Hardware control source 12:11: none, input 1, input 2, either
// R15 - Codes 09h-67h give 0.6V plus 12.5mV per step above 08h, else clamp
package bpc_pkg;
	localparam logic [15:0] ADDR_ON    = 16'h4058;
	localparam logic [15:0] ADDR_SLEEP = 16'h4059;
	// Index into the word-addressed map; byte address is four times the index
	localparam logic [15:0] ADDR_HWC   = 16'h4057;
	localparam logic [15:0] ADDR_STAT  = 16'h405f;
	localparam logic [15:0] RST_ON     = 16'h0000;
	localparam logic [15:0] RST_SLEEP  = 16'h0000;
	localparam logic [15:0] RST_HWC    = 16'h0300;
	localparam logic [15:0] MASK_ON    = 16'he37f;
	localparam logic [15:0] MASK_SLEEP = 16'he37f;
	localparam logic [15:0] MASK_HWC   = 16'h1f71;
	localparam int SLOT_HI = 15;
	localparam int SLOT_LO = 13;
	localparam int SRC_HI  = 12;
	localparam int SRC_LO  = 11;
	localparam int VCH_BIT = 10;
	localparam int MODE_HI = 9;
	localparam int MODE_LO = 8;
	localparam int THR_HI  = 6;
	localparam int THR_LO  = 4;
	localparam int DET_BIT = 0;
	localparam int VSEL_HI = 6;
	localparam logic [6:0] VCODE_MIN = 7'h08;
	localparam logic [6:0] VCODE_MAX = 7'h67;
	localparam logic [6:0] VCODE_4MHZ_MAX = 7'h48;
	localparam int STEP_UV = 12500;
	localparam int BASE_UV = 600000;
	localparam int THR_STEP_MA = 125;
	localparam logic [2:0] SLOT_OFF = 3'h0;
	localparam logic [2:0] SLOT_HW1 = 3'h6;
	localparam logic [2:0] SLOT_HW2 = 3'h7;
	localparam logic [2:0] SLP_T5   = 3'h0;
	localparam logic [2:0] SLP_T3   = 3'h6;
	localparam logic [2:0] SLP_T1   = 3'h7;
	localparam logic [2:0] SLOT_SIX = 3'h6;
	localparam logic [1:0] MODE_FCCM = 2'h0;
	localparam logic [1:0] MODE_AUTO = 2'h1;
	localparam logic [1:0] MODE_LDO  = 2'h2;
	localparam logic [1:0] MODE_HYST = 2'h3;
	localparam logic [1:0] SRC_NONE  = 2'h0;
	localparam logic [1:0] SRC_HW1   = 2'h1;
	localparam logic [1:0] SRC_HW2   = 2'h2;
	localparam logic [1:0] SRC_ANY   = 2'h3;
	localparam logic [1:0] APB_BYTE  = 2'h2;
endpackage : bpc_pkg

// ==== src/bpc_buck1_cfg.sv ====
// Register set and control decode for the first buck converter.
// Assumes APB on ref_clk; hardware control inputs and the sequencer timeslot
// strobes come from pins or other clocks and are synchronised here.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module bpc_buck1_cfg #(
	parameter int PADDR_W = 18
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               nvm_load,
	input  wire logic [4:0]         nvm_voltage_upper,
	input  wire logic               hw_control_in1,
	input  wire logic               hw_control_in2,
	input  wire logic               hw_enable_in1,
	input  wire logic               hw_enable_in2,
	input  wire logic               seq_startup,
	input  wire logic               seq_sleep,
	input  wire logic [2:0]         seq_timeslot,
	input  wire logic               high_current_raw,
	input  wire logic               fast_switching,
	output logic                    buck1_enable,
	output logic [1:0]              buck1_mode,
	output logic [6:0]              buck1_voltage_code,
	output logic [20:0]             buck1_target_uv,
	output logic [2:0]              buck1_high_current_threshold,
	output logic [10:0]             buck1_threshold_ma,
	output logic                    buck1_high_current_flag,
	output logic                    buck1_in_sleep
);
	import bpc_pkg::*;

	// Elaboration-time refusal: the register index needs paddr bits 17:2
	if (PADDR_W < 18) begin : g_paddr_check
		$error("PADDR_W too narrow for the register indices");
	end

	// -----------------------------------------------------------------
	// Register file
	// -----------------------------------------------------------------
	logic [15:0] on_cfg;
	logic [15:0] sleep_cfg;
	logic [15:0] hwc_cfg;
	logic        status_over;
	logic        nvm_d;

	wire  [15:0] reg_idx  = paddr[17:2];
	wire         aligned  = (paddr[1:0] == 2'h0);
	wire         hit_on   = aligned && (reg_idx == ADDR_ON);
	wire         hit_slp  = aligned && (reg_idx == ADDR_SLEEP);
	wire         hit_hwc  = aligned && (reg_idx == ADDR_HWC);
	wire         hit_st   = aligned && (reg_idx == ADDR_STAT);
	wire         mapped   = hit_on || hit_slp || hit_hwc || hit_st;
	wire         access   = psel && penable;
	wire         wr       = access && pwrite && mapped;

	wire [4:0] buck1_active_voltage_upper = on_cfg[VSEL_HI:2];

	// Start-up memory strobe is edge-detected so a held level loads once
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			nvm_d <= 1'b0;
		else
			nvm_d <= nvm_load;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			on_cfg <= RST_ON;
		else if (nvm_load && !nvm_d)
			on_cfg[VSEL_HI:2] <= nvm_voltage_upper; // [R08]
		else if (wr && hit_on)
			on_cfg <= pwdata[15:0] & MASK_ON; // [R05] [R06] [R07]
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			sleep_cfg <= RST_SLEEP;
		else if (wr && hit_slp)
			sleep_cfg <= pwdata[15:0] & MASK_SLEEP; // [R10] [R12] [R13]
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			hwc_cfg <= RST_HWC; // [R02] [R03] [R04]
		else if (wr && hit_hwc)
			hwc_cfg <= pwdata[15:0] & MASK_HWC; // [R14]
	end

	// Zero-wait slave: pready stands high, read data registered in setup phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= 1'b1;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite) begin
				unique case (1'b1)
					hit_on:  prdata <= {16'h0, on_cfg};
					hit_slp: prdata <= {16'h0, sleep_cfg};
					hit_hwc: prdata <= {16'h0, hwc_cfg};
					hit_st:  prdata <= {25'h0, status_over, buck1_in_sleep,
						buck1_enable, buck1_high_current_flag, buck1_mode,
						buck1_voltage_code == VCODE_MAX + 7'h1};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// Input synchronisers: a change counts once stages two and three agree
	// -----------------------------------------------------------------
	localparam int NS = 7;
	logic [NS-1:0] s1, s2, s3, clean;
	wire  [NS-1:0] raw = {hw_control_in1, hw_control_in2, hw_enable_in1, hw_enable_in2,
		seq_startup, seq_sleep, high_current_raw};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1    <= '0;
			s2    <= '0;
			s3    <= '0;
			clean <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			clean <= (s2 & s3) | (clean & (s2 | s3));
		end
	end
	wire hwc1 = clean[6];
	wire hwc2 = clean[5];
	wire hwe1 = clean[4];
	wire hwe2 = clean[3];
	wire seq_on = clean[2];
	wire seq_slp = clean[1];
	wire hc_in = clean[0];

	// -----------------------------------------------------------------
	// Power-state control
	// -----------------------------------------------------------------
	wire [2:0] on_slot  = on_cfg[SLOT_HI:SLOT_LO];
	wire [2:0] slp_slot = sleep_cfg[SLOT_HI:SLOT_LO];
	wire       hw_owned = (on_slot == SLOT_HW1) || (on_slot == SLOT_HW2);
	wire       hw_en    = (on_slot == SLOT_HW1) ? hwe1 : hwe2;
	logic      hw_ctrl;
	always_comb begin
		unique case (hwc_cfg[SRC_HI:SRC_LO]) // [R14]
			SRC_NONE: hw_ctrl = 1'b0;
			SRC_HW1:  hw_ctrl = hwc1;
			SRC_HW2:  hw_ctrl = hwc2;
			SRC_ANY:  hw_ctrl = hwc1 | hwc2;
		endcase
	end

	// Sleep-entry slot: transition codes keep it on; 001-101 count down 5..1
	logic [2:0] sleep_slot;
	logic       sleep_disables;
	always_comb begin
		sleep_disables = 1'b0;
		unique case (slp_slot) // [R10]
			SLP_T5: sleep_slot = 3'h5;
			SLP_T3: sleep_slot = 3'h3;
			SLP_T1: sleep_slot = 3'h1;
			default: begin
				sleep_slot     = SLOT_SIX - slp_slot;
				sleep_disables = !hw_owned; // [R11]
			end
		endcase
	end

	logic running;
	logic next_running;
	logic next_sleep;
	always_comb begin
		next_running = running;
		next_sleep   = buck1_in_sleep;
		if (hw_owned) begin
			next_running = hw_en; // [R05]
			if (!hw_en)
				next_sleep = 1'b0;
			else if (seq_slp && seq_timeslot == sleep_slot)
				next_sleep = 1'b1; // [R11]
			else if (!seq_slp)
				next_sleep = 1'b0;
		end else if (seq_on && on_slot != SLOT_OFF && seq_timeslot == on_slot) begin
			next_running = 1'b1; // [R05]
			next_sleep   = 1'b0;
		end else if (seq_slp && seq_timeslot == sleep_slot) begin
			next_running = running && !sleep_disables; // [R10]
			next_sleep   = running && !sleep_disables;
		end else if (!seq_slp) begin
			next_sleep = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			running        <= 1'b0;
			buck1_in_sleep <= 1'b0;
		end else begin
			running        <= next_running;
			buck1_in_sleep <= next_sleep;
		end
	end

	// Mode and voltage choice; hardware control overrides the state settings
	logic [6:0] code_sel;
	logic [1:0] mode_sel;
	always_comb begin
		if (hw_ctrl) begin
			code_sel = hwc_cfg[VCH_BIT] ? sleep_cfg[VSEL_HI:0]
				: {buck1_active_voltage_upper, on_cfg[1:0]}; // [R01]
			mode_sel = hwc_cfg[MODE_HI:MODE_LO]; // [R02]
		end else if (buck1_in_sleep) begin
			code_sel = sleep_cfg[VSEL_HI:0]; // [R13]
			mode_sel = sleep_cfg[MODE_HI:MODE_LO]; // [R12]
		end else begin
			code_sel = on_cfg[VSEL_HI:0]; // [R07]
			mode_sel = on_cfg[MODE_HI:MODE_LO]; // [R06]
		end
	end
	// Hardware mode 01 means off rather than auto mode
	wire hw_off = hw_ctrl && (hwc_cfg[MODE_HI:MODE_LO] == MODE_AUTO); // [R02]

	wire [6:0] code_clamp = (code_sel < VCODE_MIN) ? VCODE_MIN
		: (code_sel > VCODE_MAX) ? VCODE_MAX + 7'h1 : code_sel; // [R15]
	wire [20:0] step_uv = 21'(STEP_UV);
	wire [20:0] tgt_uv  = 21'(BASE_UV) + 21'(code_clamp - VCODE_MIN) * step_uv; // [R15]

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			buck1_enable       <= 1'b0;
			buck1_mode         <= MODE_FCCM;
			buck1_voltage_code <= VCODE_MIN;
			buck1_target_uv    <= 21'(BASE_UV);
			status_over        <= 1'b0;
		end else begin
			buck1_enable       <= running && !hw_off;
			buck1_mode         <= mode_sel;
			buck1_voltage_code <= code_clamp;
			buck1_target_uv    <= tgt_uv;
			// Flags a selection above the fast-switching ceiling for software
			status_over        <= fast_switching && (code_sel > VCODE_4MHZ_MAX); // [R09]
		end
	end

	// High current detect
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			buck1_high_current_threshold <= 3'h0;
			buck1_threshold_ma           <= 11'h0;
			buck1_high_current_flag      <= 1'b0;
		end else begin
			buck1_high_current_threshold <= hwc_cfg[THR_HI:THR_LO];
			buck1_threshold_ma <= 11'(THR_STEP_MA) * (11'(hwc_cfg[THR_HI:THR_LO]) + 11'h1); // [R03]
			buck1_high_current_flag <= hwc_cfg[DET_BIT] && hc_in; // [R04]
		end
	end

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_hc_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!hwc_cfg[DET_BIT] |=> !buck1_high_current_flag) // [R04]
		else $error("High current flag set while detect disabled");
	a_thr_scale: assert property (@(posedge ref_clk) disable iff (!rst_n)
		1'b1 |=> buck1_threshold_ma == 11'(THR_STEP_MA) * (11'($past(hwc_cfg[THR_HI:THR_LO])) + 11'h1)) // [R03]
		else $error("Threshold current wrong");
	a_vcode_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
		buck1_voltage_code >= VCODE_MIN && buck1_voltage_code <= VCODE_MAX + 7'h1) // [R15]
		else $error("Voltage code not clamped");
	a_target_uv: assert property (@(posedge ref_clk) disable iff (!rst_n)
		buck1_target_uv == 21'(BASE_UV) + 21'(buck1_voltage_code - VCODE_MIN) * step_uv) // [R07]
		else $error("Target voltage does not match code");
	a_hw_vsel: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hw_ctrl && hwc_cfg[VCH_BIT] && sleep_cfg[VSEL_HI:0] > VCODE_MIN
		&& sleep_cfg[VSEL_HI:0] <= VCODE_MAX |=> buck1_voltage_code == $past(sleep_cfg[VSEL_HI:0])) // [R01]
		else $error("Hardware control ignored sleep code");
	a_hw_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hw_ctrl |=> buck1_mode == $past(hwc_cfg[MODE_HI:MODE_LO])) // [R02]
		else $error("Hardware mode not applied");
	a_hw_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hw_off |=> !buck1_enable) // [R02]
		else $error("Converter on in hardware off mode");
	a_slot_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		on_slot == SLOT_OFF && !running ##1 on_slot == SLOT_OFF |-> !running) // [R05]
		else $error("Converter started with slot off");
	a_sleep_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
		buck1_in_sleep && !hw_ctrl |=> buck1_mode == $past(sleep_cfg[MODE_HI:MODE_LO])) // [R12]
		else $error("Sleep mode not applied");
	a_src_none: assert property (@(posedge ref_clk) disable iff (!rst_n)
		hwc_cfg[SRC_HI:SRC_LO] == SRC_NONE |-> !hw_ctrl) // [R14]
		else $error("Hardware control active with source none");

	c_startup: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(buck1_enable));
	c_sleep:   cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(buck1_in_sleep));
	c_hwctrl:  cover property (@(posedge ref_clk) disable iff (!rst_n) hw_ctrl && running);
	c_nvm:     cover property (@(posedge ref_clk) disable iff (!rst_n) nvm_load && !nvm_d);
endmodule : bpc_buck1_cfg
`default_nettype wire

// ==== verification/test_bpc_buck1_cfg.sv ====
// Self-checking bench for the buck1 power-state configuration block.
// Assumes zero-wait APB at 20 MHz and pin synchronisers of at most 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_bpc_buck1_cfg;
	import bpc_pkg::*;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic        nvm_load, hc1, hc2, he1, he2, s_up, s_slp, hcr, fsw;
	logic [4:0]  nvm_up;
	logic [2:0]  ts, thr;
	logic        en, hcf, slp;
	logic [1:0]  mode;
	logic [6:0]  code;
	logic [20:0] uv;
	logic [10:0] ma;
	logic [33:0] q[$];
	int          failures, check_count;
	localparam logic [17:0] A_ON = {ADDR_ON, 2'b00};
	localparam logic [17:0] A_SL = {ADDR_SLEEP, 2'b00};
	localparam logic [17:0] A_HW = {ADDR_HWC, 2'b00};
	localparam logic [17:0] A_ST = {ADDR_STAT, 2'b00};

	bpc_buck1_cfg #(.PADDR_W(18)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .nvm_load(nvm_load), .nvm_voltage_upper(nvm_up),
		.hw_control_in1(hc1), .hw_control_in2(hc2), .hw_enable_in1(he1),
		.hw_enable_in2(he2), .seq_startup(s_up), .seq_sleep(s_slp), .seq_timeslot(ts),
		.high_current_raw(hcr), .fast_switching(fsw), .buck1_enable(en), .buck1_mode(mode),
		.buck1_voltage_code(code), .buck1_target_uv(uv), .buck1_high_current_threshold(thr),
		.buck1_threshold_ma(ma), .buck1_high_current_flag(hcf), .buck1_in_sleep(slp));

	// ------------------------------------------------------------
	// Clock, checks and bus tasks
	// ------------------------------------------------------------
	initial begin
		ref_clk = 0;
		forever #25 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// Expected result is queued at setup; the monitor pops it at the access edge
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic err);
		@(posedge ref_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		q.push_back({w, err, exp});
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 0; penable <= 0;
	endtask : apb

	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		apb(1, a, d, 0, 0);
	endtask : wr

	task automatic rd(input logic [17:0] a, input logic [31:0] e);
		apb(0, a, 0, e, 0);
	endtask : rd

	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1 && q.size() > 0) begin
			chk("pslverr", pslverr, q[0][32]);
			if (!q[0][33])
				chk("prdata", prdata, q[0][31:0]);
			void'(q.pop_front());
		end
	end

	initial begin
		#(50 * 20000);
		failures++;
		tally_and_finish();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [17:0] ad [3];
		logic [15:0] mk [3];
		logic [6:0]  vc [7];
		logic [20:0] ev;
		ad = '{A_ON, A_SL, A_HW};
		mk = '{MASK_ON, MASK_SLEEP, MASK_HWC};
		vc = '{7'h00, 7'h08, 7'h09, 7'h48, 7'h67, 7'h68, 7'h7f};
		{rst_n, psel, penable, pwrite, nvm_load, hc1, hc2, he1, he2, s_up, s_slp, hcr} = 0;
		{fsw, paddr, pwdata, nvm_up, ts} = 0;
		rnd = 32'h5f06;
		cyc(20);
		rst_n <= 1;
		rd(A_ON, 0);
		rd(A_SL, 0);
		rd(A_HW, 32'h0300);
		chk("code", code, 7'h08);
		chk("target", uv, 600000);
		chk("enable", en, 0);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			wr(ad[i % 3], rnd);
			rd(ad[i % 3], {16'h0, rnd[15:0] & mk[i % 3]});
		end
		apb(0, 18'h3fffc, 0, 0, 1);
		apb(1, A_ON + 18'h2, 32'hffff, 0, 1);
		$display("test map done");
		wr(A_HW, 0);
		for (int t = 0; t < 8; t++) begin
			wr(A_HW, t << 4);
			cyc(2);
			chk("thr", thr, t);
			chk("ma", ma, 125 * (t + 1));
		end
		hcr <= 1;
		wr(A_HW, 0);
		cyc(8);
		chk("hc off", hcf, 0);
		wr(A_HW, 32'h1);
		cyc(8);
		chk("hc on", hcf, 1);
		hcr <= 0;
		wr(A_HW, 0);
		$display("test threshold done");
		foreach (vc[i]) begin
			// Fast switching only while the code stays at or below the ceiling
			fsw <= (vc[i] <= 7'h48);
			wr(A_ON, vc[i]);
			cyc(2);
			ev = vc[i] <= 7'h08 ? 600000 : vc[i] >= 7'h68 ? 1800000 : 600000 + (vc[i] - 8) * 12500;
			chk("vcode", code, vc[i] < 7'h08 ? 7'h08 : vc[i] > 7'h67 ? 7'h68 : vc[i]);
			chk("vuv", uv, ev);
			rd(A_ST, {25'h0, 6'h0, vc[i] > 7'h67});
		end
		fsw <= 0;
		$display("test voltage done");
		wr(A_ON, 32'h6120);
		wr(A_SL, 32'h4310);
		ts <= 3;
		s_up <= 1;
		cyc(8);
		chk("start en", en, 1);
		chk("start mode", mode, MODE_AUTO);
		ts <= 4;
		s_slp <= 1;
		cyc(8);
		chk("slot off", en, 0);
		{s_up, s_slp} <= 0;
		wr(A_SL, 32'hc210);
		cyc(2);
		ts <= 3;
		s_up <= 1;
		cyc(8);
		// Startup strobe must drop, or its matching slot keeps the converter awake
		s_up <= 0;
		s_slp <= 1;
		cyc(8);
		chk("sleep", slp, 1);
		chk("sleep mode", mode, MODE_LDO);
		chk("sleep uv", uv, 700000);
		rd(A_ST, {25'h0, 1'b0, 1'b1, 1'b1, 1'b0, MODE_LDO, 1'b0});
		{s_up, s_slp} <= 0;
		$display("test sequencer done");
		wr(A_ON, 32'hc020);
		he1 <= 1;
		cyc(8);
		chk("hw en", en, 1);
		hc1 <= 1;
		wr(A_HW, 32'h0c00);
		cyc(8);
		chk("hwc code", code, 7'h10);
		chk("hwc mode", mode, MODE_FCCM);
		wr(A_HW, 32'h0800);
		cyc(8);
		chk("hwc on code", code, 7'h20);
		wr(A_HW, 32'h1400);
		cyc(8);
		chk("src2 idle code", code, 7'h20);
		wr(A_HW, 32'h0900);
		cyc(8);
		chk("hw mode off", en, 0);
		wr(A_HW, 32'h0800);
		cyc(8);
		chk("hw mode on", en, 1);
		he1 <= 0;
		cyc(8);
		chk("hw off", en, 0);
		$display("test hardware done");
		nvm_up <= 5'h0a;
		nvm_load <= 1;
		cyc(1);
		nvm_load <= 0;
		cyc(2);
		rd(A_ON, 32'hc028);
		$display("test nvm done");
		cyc(4);
		tally_and_finish();
	end
endmodule : test_bpc_buck1_cfg
`default_nettype wire
